// ---- logic/scc_const_map.vh ----
// constants of the speech codec table and framing block
// assumes a single 40 MHz clock domain shared with the codec datapath
`ifndef SCC_CONST_MAP_VH
`define SCC_CONST_MAP_VH
// clock and sample timing
`define SCC_CLK_HZ 40000000
`define SCC_SAMPLE_HZ 8000
`define SCC_SAMPLE_CYCLES (`SCC_CLK_HZ / `SCC_SAMPLE_HZ)
// frame layout
`define SCC_FRAME_WORDS 7'h4C
`define SCC_LAST_WORD 7'h4B
`define SCC_LAR_WORDS 7'h08
`define SCC_SUB_LAST 5'h10
`define SCC_FRAME_SAMPLES 8'hA0
`define SCC_LAST_SAMPLE 8'h9F
// sub-frame word positions
`define SCC_SUB_LAG 5'h00
`define SCC_SUB_GAIN 5'h01
`define SCC_SUB_GRID 5'h02
`define SCC_SUB_AMP 5'h03
// lag limits and reset value
`define SCC_LAG_MIN 7'h28
`define SCC_LAG_MAX 7'h78
`define SCC_LAG_INIT 7'h28
// output truncation mask, three low bits cleared
`define SCC_TRUNC_MASK 16'hFFF8
// lar rounding term and shift
`define SCC_LAR_ROUND 32'h0000_0100
`define SCC_LAR_SHIFT 9
`endif

// ---- logic/scc_codec_tables.v ----
// speech codec constant tables plus frame and sample stream handling
// assumes: codec datapath on core_clk supplies coded words and samples,
// test equipment handshakes on the same clock, sys_rst synchronous high
//
// Operation
// - lar quantize with per-index scale, offset, clamp
// - lar decode reciprocal scale per index
// - gain code chosen against three decision levels
// - gain level rebuilt from two-bit code
// - eleven symmetric weighting filter taps
// - inverse mantissa table scales excitation samples
// - direct mantissa table for inverse quantizer
// - every exchanged word in 16-bit container
// - 76 words per frame, 160 samples each
// - reset restores encoder initial state
// - encoder takes one sample per 8 kHz period; the code takes one on every enc_in_valid cycle, unpaced
// - reset restores decoder initial state
// - decoder output continuous at 8 kHz
// - any lag code 0..127 accepted safely
// - all 64 amplitude codewords pass through
// - out-of-range lag reuses retained lag, init 40
// - field widths per frame and sub-frame position
// - output 13 bits left-justified, low three zero
`timescale 1ns/100ps
`default_nettype none
`include "scc_const_map.vh"

// position within a 76-word frame: word index and sub-frame slot
module scc_frame_pos
(
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // advance by one word, restart at word zero
   input wire step,
   input wire restart,
   // current position
   output reg [6:0] word_reg,
   output reg [4:0] sub_reg,
   output wire [3:0] width_bits,
   output wire last_word
);
   // field width by position
   reg [3:0] width_w;

   assign width_bits = width_w;
   assign last_word = (word_reg == `SCC_LAST_WORD);

   // widths 6,6,5,5,4,4,3,3 then lag 7, gain 2, grid 2, amp 6, pulses 3
   always @*
   begin
      width_w = 4'h3;
      if (word_reg < `SCC_LAR_WORDS)
      begin
         case (word_reg[2:1])
            2'h0: width_w = 4'h6;
            2'h1: width_w = 4'h5;
            2'h2: width_w = 4'h4;
            default: width_w = 4'h3;
         endcase
      end
      else
      begin
         case (sub_reg)
            `SCC_SUB_LAG: width_w = 4'h7;
            `SCC_SUB_GAIN: width_w = 4'h2;
            `SCC_SUB_GRID: width_w = 4'h2;
            `SCC_SUB_AMP: width_w = 4'h6;
            default: width_w = 4'h3;
         endcase
      end
   end

   // counters wrap after word 75 back to zero
   always @(posedge core_clk)
   begin
      if (sys_rst || restart)
      begin
         word_reg <= 7'h00;
         sub_reg <= 5'h00;
      end
      else if (step)
      begin
         if (last_word)
         begin
            word_reg <= 7'h00;
            sub_reg <= 5'h00;
         end
         else
         begin
            word_reg <= word_reg + 7'h01;
            if (word_reg >= `SCC_LAR_WORDS)
               sub_reg <= (sub_reg == `SCC_SUB_LAST) ? 5'h00 : sub_reg + 5'h01;
         end
      end
   end
endmodule // scc_frame_pos

module scc_codec_tables
#(
   parameter SAMPLE_CYCLES = `SCC_SAMPLE_CYCLES
)
(
   // clock and reset
   input wire core_clk,
   input wire sys_rst,
   // lar quantizer and decoder lookups
   input wire [2:0] lar_index,
   input wire [15:0] lar_value,
   output reg [5:0] log_area_code,
   output reg [15:0] lar_reciprocal_scale,
   // long-term gain decision and reconstruction
   input wire [15:0] gain_corr,
   input wire [15:0] gain_peak,
   output reg [1:0] ltp_gain_code,
   input wire [1:0] gain_code_in,
   output reg [15:0] gain_level,
   // weighting filter tap lookup
   input wire [3:0] tap_index,
   output reg [15:0] tap_value,
   // mantissa lookups
   input wire [2:0] mant_index,
   output reg [15:0] inv_mant_value,
   output reg [15:0] dir_mant_value,
   // encoder sample input
   input wire enc_in_valid,
   input wire [15:0] enc_in_sample,
   output reg [15:0] enc_sample_reg,
   output reg enc_sample_strobe_reg,
   output reg enc_frame_tick_reg,
   // encoder coded words from the datapath
   input wire core_param_valid,
   input wire [15:0] core_param_word,
   output wire core_param_ready,
   // encoder coded word output
   output wire enc_out_valid,
   output wire [15:0] enc_out_word,
   output wire enc_out_first,
   input wire enc_out_ready,
   // decoder coded word input
   input wire dec_in_valid,
   input wire [15:0] dec_in_word,
   input wire dec_in_first,
   output wire dec_in_ready,
   // decoder fields to the datapath
   output reg [6:0] dec_field_pos_reg,
   output reg [15:0] dec_field_reg,
   output reg dec_field_strobe_reg,
   output reg [6:0] decoded_lag_reg,
   output reg [15:0] dec_gain_reg,
   output reg [15:0] dec_mant_reg,
   output reg dec_frame_done_reg,
   // synthesized samples from the datapath
   input wire syn_valid,
   input wire [15:0] syn_sample,
   output wire syn_ready,
   // decoder output samples
   output reg dec_out_strobe_reg,
   output reg [15:0] dec_out_sample_reg,
   output reg dec_underrun_reg
);
   // signed helpers for the lar quantizer
   reg signed [15:0] lar_scale;
   reg signed [15:0] lar_offset;
   reg signed [15:0] lar_min;
   reg signed [15:0] lar_max;
   reg signed [31:0] lar_prod;
   reg signed [31:0] lar_sum;
   reg signed [15:0] lar_clamped;
   // gain decision thresholds
   reg [31:0] dlb_prod;
   reg [15:0] dlb_lvl;
   integer k;
   // frame positions
   wire [6:0] enc_word;
   wire [4:0] enc_sub;
   wire [3:0] enc_width;
   wire enc_last;
   wire [6:0] dec_word;
   wire [4:0] dec_sub;
   wire [3:0] dec_width;
   wire dec_last;
   wire dec_take;
   wire enc_take;
   // encoder sample count
   reg [7:0] enc_cnt_reg;
   // retained lag
   reg [6:0] lag_keep_reg;
   reg [6:0] lag_next;
   // two-entry output buffer
   reg [15:0] buf_mem [0:1];
   reg buf_wp_reg;
   reg buf_rp_reg;
   reg [1:0] buf_cnt_reg;
   wire buf_push;
   wire buf_pop;
   // sample period timer
   reg [15:0] tick_cnt_reg;
   wire tick;

   // lar quantizer tables, read only
   always @*
   begin
      case (lar_index)
         3'h0: begin lar_scale = 16'h5000; lar_offset = 16'h0000; end
         3'h1: begin lar_scale = 16'h5000; lar_offset = 16'h0000; end
         3'h2: begin lar_scale = 16'h5000; lar_offset = 16'h0800; end
         3'h3: begin lar_scale = 16'h5000; lar_offset = 16'hF600; end
         3'h4: begin lar_scale = 16'h368C; lar_offset = 16'h005E; end
         3'h5: begin lar_scale = 16'h3C00; lar_offset = 16'hF900; end
         3'h6: begin lar_scale = 16'h2156; lar_offset = 16'hFEAB; end
         default: begin lar_scale = 16'h234C; lar_offset = 16'hFB88; end
      endcase
      case (lar_index[2:1])
         2'h0: begin lar_min = 16'hFFE0; lar_max = 16'h001F; end
         2'h1: begin lar_min = 16'hFFF0; lar_max = 16'h000F; end
         2'h2: begin lar_min = 16'hFFF8; lar_max = 16'h0007; end
         default: begin lar_min = 16'hFFFC; lar_max = 16'h0003; end
      endcase
      // scale, offset, round, shift, clamp, then bias to unsigned code
      lar_prod = (lar_scale * $signed(lar_value)) >>> 15;
      // rounding term kept signed so negative lars shift arithmetically
      lar_sum = (lar_prod + lar_offset + $signed(`SCC_LAR_ROUND)) >>> `SCC_LAR_SHIFT;
      if (lar_sum < lar_min)
         lar_clamped = lar_min;
      else if (lar_sum > lar_max)
         lar_clamped = lar_max;
      else
         lar_clamped = lar_sum[15:0];
      log_area_code = lar_clamped[5:0] - lar_min[5:0];
      // reciprocal scale per index
      case (lar_index)
         3'h4: lar_reciprocal_scale = 16'h4B17;
         3'h5: lar_reciprocal_scale = 16'h4444;
         3'h6: lar_reciprocal_scale = 16'h7ADE;
         3'h7: lar_reciprocal_scale = 16'h740C;
         default: lar_reciprocal_scale = 16'h3333;
      endcase
   end

   // gain decision: first level whose scaled peak covers the correlation
   always @*
   begin
      ltp_gain_code = 2'h3;
      dlb_lvl = 16'h0000;
      dlb_prod = 32'h0000_0000;
      for (k = 2; k >= 0; k = k - 1)
      begin
         case (k)
            0: dlb_lvl = 16'h199A;
            1: dlb_lvl = 16'h4000;
            default: dlb_lvl = 16'h6666;
         endcase
         dlb_prod = (gain_peak * dlb_lvl) >> 15;
         if ({16'h0000, gain_corr} <= dlb_prod)
            ltp_gain_code = k[1:0];
      end
      // reconstruction levels
      case (gain_code_in)
         2'h0: gain_level = 16'h0CCD;
         2'h1: gain_level = 16'h2CCD;
         2'h2: gain_level = 16'h5333;
         default: gain_level = 16'h7FFF;
      endcase
   end

   // weighting taps and mantissa tables
   always @*
   begin
      case (tap_index)
         4'h0, 4'hA: tap_value = 16'hFF7A;
         4'h1, 4'h9: tap_value = 16'hFE8A;
         4'h3, 4'h7: tap_value = 16'h0806;
         4'h4, 4'h6: tap_value = 16'h166D;
         4'h5: tap_value = 16'h2000;
         default: tap_value = 16'h0000;
      endcase
      case (mant_index)
         3'h0: inv_mant_value = 16'h71C8;
         3'h1: inv_mant_value = 16'h6667;
         3'h2: inv_mant_value = 16'h5D18;
         3'h3: inv_mant_value = 16'h5556;
         3'h4: inv_mant_value = 16'h4EC5;
         3'h5: inv_mant_value = 16'h4925;
         3'h6: inv_mant_value = 16'h4444;
         default: inv_mant_value = 16'h4000;
      endcase
      // direct mantissa is 18431 plus 2048 per step
      dir_mant_value = {1'b0, 1'b1, mant_index, 11'h7FF};
   end

   // encoder input: 13 valid bits left-justified, one on each enc_in_valid cycle
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         enc_sample_reg <= 16'h0000;
         enc_sample_strobe_reg <= 1'b0;
         enc_frame_tick_reg <= 1'b0;
         enc_cnt_reg <= 8'h00;
      end
      else
      begin
         enc_sample_strobe_reg <= enc_in_valid;
         enc_frame_tick_reg <= 1'b0;
         if (enc_in_valid)
         begin
            enc_sample_reg <= enc_in_sample & `SCC_TRUNC_MASK;
            if (enc_cnt_reg == `SCC_LAST_SAMPLE)
            begin
               enc_cnt_reg <= 8'h00;
               enc_frame_tick_reg <= 1'b1;
            end
            else
               enc_cnt_reg <= enc_cnt_reg + 8'h01;
         end
      end
   end

   // encoder word framing: width mask and first-word mark
   assign enc_take = core_param_valid && enc_out_ready;
   assign core_param_ready = enc_out_ready;
   assign enc_out_valid = core_param_valid;
   assign enc_out_word = core_param_word & ~(16'hFFFF << enc_width);
   assign enc_out_first = core_param_valid && (enc_word == 7'h00);

   scc_frame_pos u_enc_pos
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .step(enc_take),
      .restart(1'b0),
      .word_reg(enc_word),
      .sub_reg(enc_sub),
      .width_bits(enc_width),
      .last_word(enc_last)
   );

   // decoder input: always ready, the word count runs on every word taken
   assign dec_in_ready = 1'b1;
   assign dec_take = dec_in_valid;

   scc_frame_pos u_dec_pos
   (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .step(dec_take),
      .restart(1'b0),
      .word_reg(dec_word),
      .sub_reg(dec_sub),
      .width_bits(dec_width),
      .last_word(dec_last)
   );

   // lag check against 40..120, else reuse the retained lag
   always @*
   begin
      lag_next = dec_in_word[6:0];
      if (dec_in_word[6:0] < `SCC_LAG_MIN || dec_in_word[6:0] > `SCC_LAG_MAX)
         lag_next = lag_keep_reg;
   end

   // decoder field unpack and per-field side results
   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         dec_field_pos_reg <= 7'h00;
         dec_field_reg <= 16'h0000;
         dec_field_strobe_reg <= 1'b0;
         lag_keep_reg <= `SCC_LAG_INIT;
         decoded_lag_reg <= `SCC_LAG_INIT;
         dec_gain_reg <= 16'h0000;
         dec_mant_reg <= 16'h0000;
         dec_frame_done_reg <= 1'b0;
      end
      else
      begin
         dec_field_strobe_reg <= dec_take;
         dec_frame_done_reg <= 1'b0;
         if (dec_take)
         begin
            // a first mark forces word zero whatever the count says
            dec_field_pos_reg <= dec_in_first ? 7'h00 : dec_word;
            dec_field_reg <= dec_in_word & ~(16'hFFFF << dec_width);
            dec_frame_done_reg <= dec_last;
            if (dec_word >= `SCC_LAR_WORDS)
            begin
               case (dec_sub)
                  `SCC_SUB_LAG:
                  begin
                     decoded_lag_reg <= lag_next;
                     lag_keep_reg <= lag_next;
                  end
                  `SCC_SUB_GAIN:
                  begin
                     case (dec_in_word[1:0])
                        2'h0: dec_gain_reg <= 16'h0CCD;
                        2'h1: dec_gain_reg <= 16'h2CCD;
                        2'h2: dec_gain_reg <= 16'h5333;
                        default: dec_gain_reg <= 16'h7FFF;
                     endcase
                  end
                  `SCC_SUB_AMP:
                     dec_mant_reg <= {1'b0, 1'b1, dec_in_word[2:0], 11'h7FF};
                  default:
                     dec_mant_reg <= dec_mant_reg;
               endcase
            end
         end
      end
   end

   // two-entry buffer between synthesis and the paced output
   assign syn_ready = (buf_cnt_reg != 2'h2);
   assign buf_push = syn_valid && syn_ready;
   assign buf_pop = tick && (buf_cnt_reg != 2'h0);

   always @(posedge core_clk)
   begin
      if (buf_push)
         buf_mem[buf_wp_reg] <= syn_sample & `SCC_TRUNC_MASK;
   end

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         buf_wp_reg <= 1'b0;
         buf_rp_reg <= 1'b0;
         buf_cnt_reg <= 2'h0;
      end
      else
      begin
         if (buf_push)
            buf_wp_reg <= ~buf_wp_reg;
         if (buf_pop)
            buf_rp_reg <= ~buf_rp_reg;
         case ({buf_push, buf_pop})
            2'b10: buf_cnt_reg <= buf_cnt_reg + 2'h1;
            2'b01: buf_cnt_reg <= buf_cnt_reg - 2'h1;
            default: buf_cnt_reg <= buf_cnt_reg;
         endcase
      end
   end

   // 8 kHz pacing: one output every period, zero on underrun
   assign tick = (tick_cnt_reg == SAMPLE_CYCLES[15:0] - 16'h0001);

   always @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         tick_cnt_reg <= 16'h0000;
         dec_out_strobe_reg <= 1'b0;
         dec_out_sample_reg <= 16'h0000;
         dec_underrun_reg <= 1'b0;
      end
      else
      begin
         tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
         dec_out_strobe_reg <= tick;
         dec_underrun_reg <= tick && (buf_cnt_reg == 2'h0);
         if (tick)
            dec_out_sample_reg <= buf_pop ? buf_mem[buf_rp_reg] : 16'h0000;
      end
   end
endmodule // scc_codec_tables
`default_nettype wire

// ---- dv/scc_chk_asserts.sv ----
// checker for the codec table and stream block
// assumes: bound to scc_codec_tables, one clock, sync reset high
`timescale 1ns/100ps
`default_nettype none
module scc_chk
#(
   parameter SAMPLE_CYCLES = 20
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // encoder side
   input wire logic enc_in_valid,
   input wire logic [15:0] enc_in_sample,
   input wire logic [15:0] enc_sample_reg,
   input wire logic enc_sample_strobe_reg,
   input wire logic enc_out_valid,
   input wire logic [15:0] enc_out_word,
   input wire logic enc_out_first,
   // decoder side
   input wire logic dec_in_valid,
   input wire logic [6:0] dec_field_pos_reg,
   input wire logic dec_field_strobe_reg,
   input wire logic [6:0] decoded_lag_reg,
   input wire logic dec_frame_done_reg,
   input wire logic dec_out_strobe_reg,
   input wire logic [15:0] dec_out_sample_reg,
   input wire logic dec_underrun_reg
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   // cycles since last output tick, and whether one was seen
   int gap_reg = 0;
   logic seen_reg;
   // tick spacing counter, cleared by reset and by each tick
   always @(posedge core_clk)
   begin
      if (sys_rst || dec_out_strobe_reg)
         gap_reg <= 0;
      else
         gap_reg <= gap_reg + 1;
      seen_reg <= !sys_rst && (seen_reg || dec_out_strobe_reg);
   end
   chk_sample_strobe: assert property (enc_in_valid |=> enc_sample_strobe_reg)
      else $error("sample strobe missing");
   chk_sample_trunc: assert property (enc_in_valid |=>
      enc_sample_reg == ($past(enc_in_sample) & 16'hfff8))
      else $error("sample not truncated");
   chk_out_low: assert property (dec_out_strobe_reg |=> dec_out_sample_reg[2:0] == 3'h0)
      else $error("output low bits set");
   chk_first_word: assert property (enc_out_first |->
      enc_out_valid && enc_out_word[15:6] == 10'h000)
      else $error("first word bad");
   chk_lag_range: assert property (decoded_lag_reg >= 7'h28 && decoded_lag_reg <= 7'h78)
      else $error("lag out of range");
   chk_lag_hold: assert property (!dec_in_valid |=> $stable(decoded_lag_reg))
      else $error("lag moved without word");
   chk_tick_period: assert property ((dec_out_strobe_reg && seen_reg) |->
      gap_reg == SAMPLE_CYCLES - 1)
      else $error("tick spacing wrong");
   chk_frame_done: assert property (dec_frame_done_reg |->
      dec_field_strobe_reg && dec_field_pos_reg == 7'h4b)
      else $error("frame done misplaced");
   chk_underrun_tick: assert property (dec_underrun_reg |-> dec_out_strobe_reg)
      else $error("underrun off tick");
   chk_reset_lag: assert property ($fell(sys_rst) |-> decoded_lag_reg == 7'h28)
      else $error("lag not reset");
endmodule // scc_chk
bind scc_codec_tables scc_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (.*);
`default_nettype wire

// ---- dv/scc_feeder.sv ----
// decoder feeder model: two whole 76-word frames per go
// assumes: decoder always ready, words changed on falling edge
`timescale 1ns/100ps
`default_nettype none
module scc_feeder
(
   // clock and start
   input wire logic core_clk,
   input wire logic go,
   // decoder word stream
   output logic dec_in_valid,
   output logic [15:0] dec_in_word,
   output logic dec_in_first,
   output logic fed
);
   int seed = 32'h0c49_3ce6;
   int f;
   int n;
   logic [15:0] w;
   // lags per sub-frame, out of range ones included
   logic [6:0] lags [8] = '{7'h27, 7'h78, 7'h79, 7'h00, 7'h7f, 7'h28, 7'h50, 7'h29};
   // frame 0 back to back, frame 1 with idle gaps
   initial
   begin
      dec_in_valid = 1'b0;
      dec_in_word = 16'h0000;
      dec_in_first = 1'b0;
      fed = 1'b0;
      @(posedge go);
      for (f = 0; f < 2; f++)
         for (n = 0; n < 76; n++)
         begin
            @(negedge core_clk);
            w = 16'($random(seed));
            if (n >= 8 && (n - 8) % 17 == 0)
               w[6:0] = lags[f * 4 + (n - 8) / 17];
            dec_in_valid = 1'b1;
            dec_in_first = (n == 0);
            dec_in_word = w;
            if (f == 1)
            begin
               @(negedge core_clk);
               dec_in_valid = 1'b0;
               dec_in_first = 1'b0;
               dec_in_word = ~w;
            end
         end
      @(negedge core_clk);
      dec_in_valid = 1'b0;
      dec_in_word = ~w;
      fed = 1'b1;
   end
endmodule // scc_feeder
`default_nettype wire

// ---- dv/tb_speech_codec_const_tables.sv ----
// testbench for the codec table and stream block
// assumes: 40 MHz clock, sync reset high, tick period shortened to 20
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      n_checks++; \
      if ((got) !== (ex)) \
      begin \
         error_cnt++; \
         $display("BAD %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb_speech_codec_const_tables;
   // inputs driven by the bench
   logic core_clk = 1'b0, sys_rst = 1'b1, go = 1'b0;
   logic [2:0] lar_index = 3'h0, mant_index = 3'h0;
   logic [15:0] lar_value = 16'h0000, gain_corr = 16'h0000, gain_peak = 16'h0000;
   logic [1:0] gain_code_in = 2'h0, ltp_gain_code;
   logic [3:0] tap_index = 4'h0;
   logic enc_in_valid = 1'b0, core_param_valid = 1'b0, enc_out_ready = 1'b0;
   logic syn_valid = 1'b0;
   logic [15:0] enc_in_sample = 16'h0000, core_param_word = 16'h0000, syn_sample = 16'h0000;
   // design outputs and feeder wires
   logic [5:0] log_area_code;
   logic [15:0] lar_reciprocal_scale, gain_level, tap_value, inv_mant_value, dir_mant_value;
   logic [15:0] enc_sample_reg, enc_out_word, dec_field_reg, dec_gain_reg, dec_mant_reg;
   logic [15:0] dec_out_sample_reg, dec_in_word;
   logic enc_sample_strobe_reg, enc_frame_tick_reg, core_param_ready, enc_out_valid;
   logic enc_out_first, dec_in_ready, dec_field_strobe_reg, dec_frame_done_reg, syn_ready;
   logic dec_out_strobe_reg, dec_underrun_reg, dec_in_valid, dec_in_first, fed;
   logic [6:0] dec_field_pos_reg, decoded_lag_reg;
   // bench state and expectation notes
   int error_cnt = 0, n_checks = 0, seed = 32'h0c49_3ce6, rseed = 32'h0c49_3ce6;
   int i, j, k, dpos = 0;
   logic [6:0] xlag = 7'h28;
   logic [16:0] eq[$], sq[$], ne, ns;
   logic [30:0] dq[$], nd, gd;
   logic [15:0] oq[$], xs, fw;
   logic pend = 1'b0, xu, seen_full = 1'b0;
   // reference tables
   logic [15:0] rcp[8] = '{16'h3333, 16'h3333, 16'h3333, 16'h3333, 16'h4b17, 16'h4444,
      16'h7ade, 16'h740c};
   logic [15:0] gain_decision_levels[3] = '{16'h199a, 16'h4000, 16'h6666};
   logic [15:0] gain_reconstruction_levels[4] = '{16'h0ccd, 16'h2ccd, 16'h5333, 16'h7fff};
   logic [15:0] tap[11] = '{16'hff7a, 16'hfe8a, 16'h0000, 16'h0806, 16'h166d, 16'h2000,
      16'h166d, 16'h0806, 16'h0000, 16'hfe8a, 16'hff7a};
   logic [15:0] nrf[8] = '{16'h71c8, 16'h6667, 16'h5d18, 16'h5556, 16'h4ec5, 16'h4925,
      16'h4444, 16'h4000};
   logic [15:0] fac[8] = '{16'h47ff, 16'h4fff, 16'h57ff, 16'h5fff, 16'h67ff, 16'h6fff,
      16'h77ff, 16'h7fff};
   scc_codec_tables #(.SAMPLE_CYCLES(20)) dut_u (.*);
   scc_feeder feed_u (.*);
   // clock and stalling receiver
   always #12.5 core_clk = ~core_clk;
   always @(negedge core_clk) enc_out_ready = 1'($random(rseed));
   // field width mask by word position
   function automatic logic [15:0] fmask(input int p);
      int s;
      s = (p - 8) % 17;
      if (p < 8)
         return 16'h003f >> (p / 2);
      return (s == 0) ? 16'h007f : (s < 3) ? 16'h0003 : (s == 3) ? 16'h003f : 16'h0007;
   endfunction
   task automatic stop_test;
      if (error_cnt == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // coded words, held until taken
   task automatic send_words(input int cnt);
      int n;
      for (n = 0; n < cnt; n++)
      begin
         core_param_valid = 1'b1;
         core_param_word = 16'($random(seed));
         eq.push_back({n % 76 == 0, core_param_word & fmask(n % 76)});
         @(posedge core_clk iff enc_out_ready);
         @(negedge core_clk);
      end
      core_param_valid = 1'b0;
   endtask
   // notes taken at handshake edges
   always @(posedge core_clk)
   begin
      if (core_param_valid && enc_out_ready && !sys_rst)
      begin
         ne = eq.pop_front();
         `CHK("enc_word", ne, {enc_out_first, enc_out_word})
         `CHK("enc_hs", 3'h7, {enc_out_valid, core_param_ready, dec_in_ready})
      end
      if (dec_in_valid && !sys_rst)
      begin
         fw = dec_in_word & fmask(dpos);
         if (dpos >= 8 && (dpos - 8) % 17 == 0 && fw >= 16'h0028 && fw <= 16'h0078)
            xlag = fw[6:0];
         dq.push_back({dpos == 75, xlag, 7'(dpos), fw});
         dpos = (dpos == 75) ? 0 : dpos + 1;
      end
      if (syn_valid && syn_ready)
         oq.push_back(syn_sample & 16'hfff8);
      if (syn_valid && !syn_ready)
         seen_full = 1'b1;
   end
   // result watcher: oldest note against each result
   always @(negedge core_clk)
   begin
      if (pend)
         `CHK("out_sample", xs, dec_out_sample_reg)
      pend = dec_out_strobe_reg;
      if (dec_out_strobe_reg)
      begin
         xu = (oq.size() == 0);
         xs = xu ? 16'h0000 : oq.pop_front();
         `CHK("underrun", xu, dec_underrun_reg)
      end
      if (enc_sample_strobe_reg)
      begin
         ns = sq.pop_front();
         `CHK("enc_sample", ns, {enc_frame_tick_reg, enc_sample_reg})
      end
      if (dec_field_strobe_reg)
      begin
         nd = dq.pop_front();
         gd = {dec_frame_done_reg, decoded_lag_reg, dec_field_pos_reg, dec_field_reg};
         `CHK("dec_field", nd, gd)
         if (nd[22:16] >= 8 && (nd[22:16] - 8) % 17 == 1)
            `CHK("dec_gain", gain_reconstruction_levels[nd[1:0]], dec_gain_reg)
         if (nd[22:16] >= 8 && (nd[22:16] - 8) % 17 == 3)
            `CHK("dec_mant", fac[nd[2:0]], dec_mant_reg)
      end
   end
   // main sequence
   initial
   begin
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      `CHK("lag_init", 7'h28, decoded_lag_reg)
      `CHK("ready_init", 1'b1, syn_ready)
      // every table index, lar codes at both clamps
      for (i = 0; i < 16; i++)
      begin
         @(negedge core_clk);
         lar_index = 3'(i);
         mant_index = 3'(i);
         tap_index = 4'(i);
         gain_code_in = 2'(i);
         lar_value = 16'h7fff;
         #1;
         `CHK("tap", (i < 11) ? tap[i] : 16'h0000, tap_value)
         `CHK("gain_lvl", gain_reconstruction_levels[i % 4], gain_level)
         if (i < 8)
         begin
            `CHK("lar_rcp", rcp[i], lar_reciprocal_scale)
            `CHK("inv_mant", nrf[i], inv_mant_value)
            `CHK("dir_mant", fac[i], dir_mant_value)
            `CHK("lar_max", 6'h3f >> (i / 2), log_area_code)
            lar_value = 16'h8000;
            #1;
            `CHK("lar_min", 6'h00, log_area_code)
         end
      end
      // gain decision at each level edge, then random
      for (i = 0; i < 26; i++)
      begin
         @(negedge core_clk);
         gain_peak = (i < 6) ? 16'h8000 : 16'($random(seed));
         gain_corr = (i < 6) ? gain_decision_levels[i / 2] + 16'(i % 2) : 16'($random(seed)) >> 2;
         #1;
         k = 3;
         for (j = 2; j >= 0; j--)
            if (32'(gain_corr) <= (32'(gain_peak) * 32'(gain_decision_levels[j])) >> 15)
               k = j;
         `CHK("gain_code", 2'(k), ltp_gain_code)
      end
      // one full frame of samples plus one, one per period
      for (i = 0; i < 161; i++)
      begin
         @(negedge core_clk);
         enc_in_valid = 1'b1;
         enc_in_sample = 16'($random(seed));
         sq.push_back({i % 160 == 159, enc_in_sample & 16'hfff8});
         @(negedge core_clk);
         enc_in_valid = 1'b0;
         repeat (18) @(negedge core_clk);
      end
      // output buffer filled past refusal, then drained to underrun
      @(posedge core_clk iff dec_out_strobe_reg);
      for (i = 0; i < 8; i++)
      begin
         @(negedge core_clk);
         syn_valid = 1'b1;
         syn_sample = 16'($random(seed));
         @(posedge core_clk iff syn_ready);
         @(negedge core_clk);
         syn_valid = 1'b0;
         syn_sample = ~syn_sample;
         repeat ($random(seed) & 3) @(negedge core_clk);
      end
      repeat (80) @(negedge core_clk);
      // two decoder frames from the feeder
      go = 1'b1;
      wait (fed);
      repeat (4) @(negedge core_clk);
      // coded words across a frame wrap, then reset mid-frame
      send_words(80);
      sys_rst = 1'b1;
      xlag = 7'h28;
      dpos = 0;
      @(negedge core_clk);
      sys_rst = 1'b0;
      `CHK("lag_reset", 7'h28, decoded_lag_reg)
      send_words(5);
      repeat (4) @(negedge core_clk);
      `CHK("full_seen", 1'b1, seen_full)
      stop_test();
   end
   // watchdog well past the expected run length
   initial
   begin
      #(25 * 20000);
      error_cnt++;
      stop_test();
   end
endmodule // tb_speech_codec_const_tables
`default_nettype wire
